// *** hdl/gorb_axis_path.sv ***
`timescale 1ns/10ps
`default_nettype none
module gorb_axis_path (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_in,
  input wire logic signed [15:0] raw_in,
  input wire logic signed [15:0] temp_in,
  input wire logic signed [9:0] coeff_in,
  input wire logic signed [15:0] user_in,
  output gorb_pkg::gorb_word_t rate_out
);
  logic signed [25:0] comp_full;
  logic signed [17:0] sum_d;

  ////////////////////////////////////////////////////////////////////////////
  // Compensation term, zero coefficient adds nothing
  always_comb begin
    comp_full = coeff_in * temp_in;
    sum_d = 18'(raw_in) - 18'(user_in) - 18'(comp_full >>> 10);
  end

  // Saturated result into the output pair
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rate_out <= 16'sh0000;
    end else if (sample_in) begin
      if (sum_d > 18'sh07FFF) begin
        rate_out <= 16'sh7FFF;
      end else if (sum_d < -18'sh08000) begin
        rate_out <= 16'sh8000;
      end else begin
        rate_out <= sum_d[15:0];
      end
    end
  end
endmodule // gorb_axis_path
`default_nettype wire

// *** hdl/gorb_defines.svh ***
`ifndef GORB_DEFINES_SVH
`define GORB_DEFINES_SVH

// Register offsets
`define GORB_X_TC_HIGH 8'h04
`define GORB_X_TC_LOW 8'h05
`define GORB_Y_TC_HIGH 8'h07
`define GORB_Y_TC_LOW 8'h08
`define GORB_Z_TC_HIGH 8'h0A
`define GORB_Z_TC_LOW 8'h0B
`define GORB_X_USR_HIGH 8'h13
`define GORB_X_USR_LOW 8'h14
`define GORB_Y_USR_HIGH 8'h15
`define GORB_Y_USR_LOW 8'h16
`define GORB_Z_USR_HIGH 8'h17
`define GORB_Z_USR_LOW 8'h18
`define GORB_TEMP_HIGH 8'h41
`define GORB_TEMP_LOW 8'h42
`define GORB_X_RATE_HIGH 8'h43
`define GORB_X_RATE_LOW 8'h44
`define GORB_Y_RATE_HIGH 8'h45
`define GORB_Y_RATE_LOW 8'h46
`define GORB_Z_RATE_HIGH 8'h47
`define GORB_Z_RATE_LOW 8'h48
`define GORB_HOST_CTRL 8'h6A
`define GORB_PWR_PRIMARY 8'h6B
`define GORB_PWR_STANDBY 8'h6C
`define GORB_QLEVEL_HIGH 8'h72
`define GORB_QLEVEL_LOW 8'h73
`define GORB_QDATA 8'h74
`define GORB_IDENTITY 8'h75

// Field positions and widths
`define GORB_FULL_RESET_BIT 7
`define GORB_SLEEP_BIT 6
`define GORB_TC_WIDTH 10
`define GORB_TC_HIGH_MASK 8'h03
`define GORB_STANDBY_MASK 8'h07

// Reset values
`define GORB_RESET_VALUE 8'h00
`define GORB_RESET_WORD 16'h0000

`endif

// *** hdl/gorb_pkg.sv ***
package gorb_pkg;
  typedef logic [7:0] gorb_byte_t;
  typedef logic signed [15:0] gorb_word_t;
  typedef logic signed [9:0] gorb_coeff_t;
  typedef enum logic [1:0] {
    GORB_LOAD,
    GORB_RUN
  } gorb_state_t;
endpackage

// *** hdl/gorb_register_bank.sv ***
// Summary of operation
// RULE_01: After reset all registers read zero; identity register reads its code. Coefficient registers read the loaded trim instead.
// RULE_02: Split values show upper byte in high register, lower in low.
// RULE_03: Device powers up awake with sleep cleared, measuring at once. Rates update only after the trim load ends.
// RULE_04: Factory trim coefficients load at power-up and on full reset.
// RULE_05: Compensation always active; zero coefficient has no effect.
// RULE_06: Coefficients are signed 10-bit, two bits high, eight low.
// RULE_07: Host may overwrite coefficients; trim returns only on reset.
// RULE_08: User offset is subtracted from raw rate before output.
// RULE_09: Writes to read-only registers are ignored.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "gorb_defines.svh"
module gorb_register_bank #(
  parameter logic [7:0] IDENTITY_CODE = 8'h5A // Arbitrary value
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic sample_in,
  input wire logic [15:0] x_raw_in,
  input wire logic [15:0] y_raw_in,
  input wire logic [15:0] z_raw_in,
  input wire logic [15:0] temp_in,
  input wire logic [29:0] trim_in,
  output logic sleep_out,
  output logic [2:0] standby_out,
  output logic loading_out
);
  gorb_pkg::gorb_state_t state_q;
  logic [1:0] load_axis_q;
  logic [1:0] load_cnt_q;
  logic [9:0] rom_coeff;
  logic [9:0] tc_q [3];
  logic [15:0] usr_q [3];
  logic [15:0] raw [3];
  gorb_pkg::gorb_word_t rate [3];
  logic [15:0] temp_q;
  logic [7:0] host_ctrl_q;
  logic [7:0] pwr1_q;
  logic [7:0] pwr2_q;
  logic full_reset;
  logic soft_rst;

  function automatic logic [1:0] tc_axis(input logic [7:0] a);
    case (a)
      `GORB_X_TC_HIGH, `GORB_X_TC_LOW: tc_axis = 2'h0;
      `GORB_Y_TC_HIGH, `GORB_Y_TC_LOW: tc_axis = 2'h1;
      `GORB_Z_TC_HIGH, `GORB_Z_TC_LOW: tc_axis = 2'h2;
      default: tc_axis = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] usr_axis(input logic [7:0] a);
    case (a)
      `GORB_X_USR_HIGH, `GORB_X_USR_LOW: usr_axis = 2'h0;
      `GORB_Y_USR_HIGH, `GORB_Y_USR_LOW: usr_axis = 2'h1;
      `GORB_Z_USR_HIGH, `GORB_Z_USR_LOW: usr_axis = 2'h2;
      default: usr_axis = 2'h3;
    endcase
  endfunction

  // High registers of each pair sit at the lower offset
  function automatic logic is_high(input logic [7:0] a);
    case (a)
      `GORB_X_TC_HIGH, `GORB_Y_TC_HIGH, `GORB_Z_TC_HIGH,
      `GORB_X_USR_HIGH, `GORB_Y_USR_HIGH, `GORB_Z_USR_HIGH: is_high = 1'b1;
      default: is_high = 1'b0;
    endcase
  endfunction

  assign full_reset = wr_in && addr_in == `GORB_PWR_PRIMARY &&
                      wdata_in[`GORB_FULL_RESET_BIT];
  assign soft_rst = sys_rst_in || full_reset;
  assign raw[0] = x_raw_in;
  assign raw[1] = y_raw_in;
  assign raw[2] = z_raw_in;
  assign loading_out = state_q == gorb_pkg::GORB_LOAD;

  ////////////////////////////////////////////////////////////////////////////
  // Trim load sequencer
  gorb_trim_rom u_trim (
    .sys_clk_in(sys_clk_in),
    .axis_in(load_axis_q),
    .trim_in(trim_in),
    .coeff_out(rom_coeff)
  );

  // RULE_04: reload on full reset
  always_ff @(posedge sys_clk_in) begin
    if (soft_rst) begin
      state_q <= gorb_pkg::GORB_LOAD;
      load_axis_q <= 2'h0;
      load_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        gorb_pkg::GORB_LOAD: begin
          load_cnt_q <= load_cnt_q + 2'h1;
          // Store read lags its address by one cycle
          load_axis_q <= load_axis_q + 2'h1;
          if (load_cnt_q == 2'h3) begin
            state_q <= gorb_pkg::GORB_RUN;
          end
        end
        gorb_pkg::GORB_RUN: state_q <= gorb_pkg::GORB_RUN;
        default: state_q <= gorb_pkg::GORB_LOAD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-axis compensation, offset and datapath
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      // RULE_04: copy trim into coefficient
      // RULE_07: host writes override trim
      always_ff @(posedge sys_clk_in) begin
        if (soft_rst) begin
          tc_q[g] <= 10'h000;
        end else if (loading_out && load_cnt_q == 2'(g + 1)) begin
          tc_q[g] <= rom_coeff;
        end else if (wr_in && tc_axis(addr_in) == 2'(g)) begin
          // RULE_06: two high bits, eight low bits
          if (is_high(addr_in)) begin
            tc_q[g][9:8] <= wdata_in[1:0];
          end else begin
            tc_q[g][7:0] <= wdata_in;
          end
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (soft_rst) begin
          usr_q[g] <= `GORB_RESET_WORD;
        end else if (wr_in && usr_axis(addr_in) == 2'(g)) begin
          if (is_high(addr_in)) begin
            usr_q[g][15:8] <= wdata_in;
          end else begin
            usr_q[g][7:0] <= wdata_in;
          end
        end
      end

      // RULE_05: compensation always active
      // RULE_08: subtract user offset
      gorb_axis_path u_path (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(soft_rst),
        .sample_in(sample_in && !sleep_out && !pwr2_q[2 - g] && !loading_out),
        .raw_in(raw[g]),
        .temp_in(temp_q),
        .coeff_in(tc_q[g]),
        .user_in(usr_q[g]),
        .rate_out(rate[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Temperature capture
  always_ff @(posedge sys_clk_in) begin
    if (soft_rst) begin
      temp_q <= `GORB_RESET_WORD;
    end else if (sample_in && !sleep_out) begin
      temp_q <= temp_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  // RULE_03: awake after power-up
  always_ff @(posedge sys_clk_in) begin
    if (soft_rst) begin
      pwr1_q <= `GORB_RESET_VALUE;
      pwr2_q <= `GORB_RESET_VALUE;
      host_ctrl_q <= `GORB_RESET_VALUE;
    end else if (wr_in) begin
      case (addr_in)
        `GORB_PWR_PRIMARY: pwr1_q <= wdata_in;
        `GORB_PWR_STANDBY: pwr2_q <= wdata_in & `GORB_STANDBY_MASK;
        `GORB_HOST_CTRL: host_ctrl_q <= wdata_in;
        default: pwr1_q <= pwr1_q;
      endcase
    end
  end

  assign sleep_out = pwr1_q[`GORB_SLEEP_BIT];
  assign standby_out = pwr2_q[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // RULE_09: read-only registers have no write path
  // RULE_02: high byte then low byte
  // RULE_01: zero reset, identity code
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= `GORB_RESET_VALUE;
    end else if (rd_in) begin
      case (addr_in)
        `GORB_X_TC_HIGH: rdata_out <= {6'h00, tc_q[0][9:8]};
        `GORB_X_TC_LOW: rdata_out <= tc_q[0][7:0];
        `GORB_Y_TC_HIGH: rdata_out <= {6'h00, tc_q[1][9:8]};
        `GORB_Y_TC_LOW: rdata_out <= tc_q[1][7:0];
        `GORB_Z_TC_HIGH: rdata_out <= {6'h00, tc_q[2][9:8]};
        `GORB_Z_TC_LOW: rdata_out <= tc_q[2][7:0];
        `GORB_X_USR_HIGH: rdata_out <= usr_q[0][15:8];
        `GORB_X_USR_LOW: rdata_out <= usr_q[0][7:0];
        `GORB_Y_USR_HIGH: rdata_out <= usr_q[1][15:8];
        `GORB_Y_USR_LOW: rdata_out <= usr_q[1][7:0];
        `GORB_Z_USR_HIGH: rdata_out <= usr_q[2][15:8];
        `GORB_Z_USR_LOW: rdata_out <= usr_q[2][7:0];
        `GORB_TEMP_HIGH: rdata_out <= temp_q[15:8];
        `GORB_TEMP_LOW: rdata_out <= temp_q[7:0];
        `GORB_X_RATE_HIGH: rdata_out <= rate[0][15:8];
        `GORB_X_RATE_LOW: rdata_out <= rate[0][7:0];
        `GORB_Y_RATE_HIGH: rdata_out <= rate[1][15:8];
        `GORB_Y_RATE_LOW: rdata_out <= rate[1][7:0];
        `GORB_Z_RATE_HIGH: rdata_out <= rate[2][15:8];
        `GORB_Z_RATE_LOW: rdata_out <= rate[2][7:0];
        `GORB_HOST_CTRL: rdata_out <= host_ctrl_q;
        // Self-clearing full reset bit never reads back
        `GORB_PWR_PRIMARY: rdata_out <= pwr1_q & 8'h7F;
        `GORB_PWR_STANDBY: rdata_out <= pwr2_q;
        `GORB_IDENTITY: rdata_out <= IDENTITY_CODE;
        default: rdata_out <= `GORB_RESET_VALUE;
      endcase
    end else begin
      rdata_out <= `GORB_RESET_VALUE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // RULE_03: awake after reset
  a_awake_after_reset: assert property (@(posedge sys_clk_in) // RULE_03
    disable iff (sys_rst_in)
    $past(sys_rst_in) |-> !sleep_out)
    else $error("sleep set after reset");

  // RULE_04: load ends four cycles after reset
  a_trim_load_done: assert property (@(posedge sys_clk_in) // RULE_04
    $fell(soft_rst) |-> ##4 !loading_out)
    else $error("trim load did not finish");

  // RULE_04: x coefficient equals trim after load
  a_trim_x_loaded: assert property (@(posedge sys_clk_in) // RULE_04
    disable iff (soft_rst)
    $fell(loading_out) && !$past(wr_in) |-> tc_q[0] == trim_in[9:0])
    else $error("x trim not loaded");

  // RULE_01: identity read
  a_identity_read: assert property (@(posedge sys_clk_in) // RULE_01
    disable iff (sys_rst_in)
    rd_in && addr_in == `GORB_IDENTITY |=> rdata_out == IDENTITY_CODE)
    else $error("identity mismatch");

  // RULE_09: x rate ignores writes to its high register
  a_rate_ro: assert property (@(posedge sys_clk_in) // RULE_09
    disable iff (soft_rst)
    wr_in && addr_in == `GORB_X_RATE_HIGH && !sample_in |=> $stable(rate[0]))
    else $error("rate changed by write");

  // RULE_07: host write lands in coefficient
  a_tc_write: assert property (@(posedge sys_clk_in) // RULE_07
    disable iff (soft_rst)
    !loading_out && wr_in && addr_in == `GORB_Y_TC_LOW
    |=> tc_q[1][7:0] == $past(wdata_in))
    else $error("coefficient write lost");

  // RULE_02: low byte read
  a_usr_low_read: assert property (@(posedge sys_clk_in) // RULE_02
    disable iff (soft_rst)
    rd_in && addr_in == `GORB_Z_USR_LOW |=> rdata_out == $past(usr_q[2][7:0]))
    else $error("low byte wrong");

  // RULE_06: upper coefficient bits read masked
  a_tc_high_mask: assert property (@(posedge sys_clk_in) // RULE_06
    disable iff (sys_rst_in)
    rd_in && addr_in == `GORB_X_TC_HIGH |=> rdata_out[7:2] == 6'h00)
    else $error("reserved bits set");

  // RULE_08: zero coefficient leaves raw minus offset
  a_rate_subtract: assert property (@(posedge sys_clk_in) // RULE_08
    disable iff (soft_rst)
    sample_in && !sleep_out && !loading_out && !pwr2_q[2] && tc_q[0] == 10'h000
    && !wr_in |=> rate[0] == $past(16'(x_raw_in - usr_q[0])) ||
    $past(x_raw_in[15] != usr_q[0][15]))
    else $error("offset not subtracted");

  // RULE_04: y and z trim after load
  a_trim_yz_loaded: assert property (@(posedge sys_clk_in) // RULE_04
    disable iff (soft_rst)
    $fell(loading_out) && !$past(wr_in)
    |-> tc_q[1] == trim_in[19:10] && tc_q[2] == trim_in[29:20])
    else $error("y or z trim not loaded");

  // RULE_01: full reset clears x offset and standby register
  a_full_reset_clear: assert property (@(posedge sys_clk_in) // RULE_01
    disable iff (sys_rst_in)
    $past(soft_rst) |-> usr_q[0] == 16'h0000 && pwr2_q == 8'h00)
    else $error("offset kept over reset");

  // RULE_01: read data idle at zero
  a_rdata_idle: assert property (@(posedge sys_clk_in) // RULE_01
    disable iff (sys_rst_in)
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");

  // RULE_02: rate high byte read
  a_rate_high_read: assert property (@(posedge sys_clk_in) // RULE_02
    disable iff (sys_rst_in)
    rd_in && addr_in == `GORB_Y_RATE_HIGH
    |=> rdata_out == $past(rate[1][15:8]))
    else $error("rate high byte wrong");

  // RULE_02: temperature captured on sample
  a_temp_capture: assert property (@(posedge sys_clk_in) // RULE_02
    disable iff (soft_rst)
    sample_in && !sleep_out |=> temp_q == $past(temp_in))
    else $error("temperature not captured");

  // RULE_03: sleep freezes outputs
  a_sleep_hold: assert property (@(posedge sys_clk_in) // RULE_03
    disable iff (soft_rst)
    sleep_out |=> $stable(rate[2]) && $stable(temp_q))
    else $error("output changed in sleep");

  // RULE_07: high coefficient write lands
  a_tc_high_write: assert property (@(posedge sys_clk_in) // RULE_07
    disable iff (soft_rst)
    !loading_out && wr_in && addr_in == `GORB_Z_TC_HIGH
    |=> tc_q[2][9:8] == $past(wdata_in[1:0]))
    else $error("coefficient high write lost");

  // RULE_02: user offset high byte write
  a_usr_high_write: assert property (@(posedge sys_clk_in) // RULE_02
    disable iff (soft_rst)
    wr_in && addr_in == `GORB_X_USR_HIGH
    |=> usr_q[0][15:8] == $past(wdata_in))
    else $error("offset high write lost");

  // RULE_03: sleep follows written bit
  a_sleep_write: assert property (@(posedge sys_clk_in) // RULE_03
    disable iff (soft_rst)
    wr_in && addr_in == `GORB_PWR_PRIMARY
    |=> sleep_out == $past(wdata_in[`GORB_SLEEP_BIT]))
    else $error("sleep bit not stored");

  // RULE_08: standby axis keeps output
  a_standby_hold: assert property (@(posedge sys_clk_in) // RULE_08
    disable iff (soft_rst)
    pwr2_q[1] |=> $stable(rate[1]))
    else $error("standby axis changed");
endmodule // gorb_register_bank
`default_nettype wire

// *** hdl/gorb_trim_rom.sv ***
`timescale 1ns/10ps
`default_nettype none
module gorb_trim_rom (
  input wire logic sys_clk_in,
  input wire logic [1:0] axis_in,
  input wire logic [29:0] trim_in,
  output logic [9:0] coeff_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Registered read of the factory trim store
  always_ff @(posedge sys_clk_in) begin
    case (axis_in)
      2'h0: coeff_out <= trim_in[9:0];
      2'h1: coeff_out <= trim_in[19:10];
      2'h2: coeff_out <= trim_in[29:20];
      default: coeff_out <= 10'h000;
    endcase
  end
endmodule // gorb_trim_rom
`default_nettype wire

// *** sim/gorb_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module gorb_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'hFF;
    wdata_out = 8'hFF;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // host overwrites values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge sys_clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge sys_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule // gorb_host_model
`default_nettype wire

// *** sim/tb_gorb_register_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_gorb_register_bank;
  // Arbitrary identity value
  localparam logic [7:0] ID = 8'hA5;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, sleep_out, loading_out;
  logic [2:0] standby_out;
  logic sample_in = 1'b0;
  logic signed [15:0] raw [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic signed [15:0] tmp = 16'h0000;
  logic [29:0] trim_in = 30'h0;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h61d9;

  always #2 sys_clk_in = ~sys_clk_in;

  gorb_register_bank #(.IDENTITY_CODE(ID)) i_gorb_register_bank (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .sample_in(sample_in), .x_raw_in(raw[0]), .y_raw_in(raw[1]),
    .z_raw_in(raw[2]), .temp_in(tmp), .trim_in(trim_in),
    .sleep_out(sleep_out), .standby_out(standby_out),
    .loading_out(loading_out));

  gorb_host_model i_gorb_host_model (
    .sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_gorb_host_model.rd(a, d);
    chk8(d, exp);
  endtask

  task automatic wait_load();
    int n;
    repeat (2) @(posedge sys_clk_in);
    #1;
    n = 0;
    while (loading_out !== 1'b0 && n < 50) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    chk8({7'h00, loading_out}, 8'h00);
  endtask

  function automatic logic [15:0] exp_rate(int r, int u, int t, int c);
    int v;
    v = r - u - ((c * t) >>> 10);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    stop_test();
  end

  initial begin
    logic [7:0] regs [25] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B,
      8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h42, 8'h43, 8'h44,
      8'h45, 8'h46, 8'h47, 8'h48, 8'h6A, 8'h6B, 8'h6C, 8'h72, 8'h73,
      8'h74};
    logic signed [15:0] usr [3];
    logic signed [9:0] cf [3];
    logic [15:0] e [3];
    logic [9:0] c;
    logic signed [15:0] tp;
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    wait_load();
    foreach (regs[i]) rchk(regs[i], 8'h00);
    rchk(8'h75, ID);
    chk8({7'h00, sleep_out}, 8'h00);
    chk8({5'h00, standby_out}, 8'h00);
    // Full reset reloads trim
    trim_in <= 30'($random(seed));
    i_gorb_host_model.wr(8'h6B, 8'h80);
    wait_load();
    for (int i = 0; i < 3; i++) begin
      c = trim_in[i*10 +: 10];
      rchk(8'(8'h04 + 3 * i), {6'h00, c[9:8]});
      rchk(8'(8'h05 + 3 * i), c[7:0]);
    end
    // Random rates with saturation and zero-coefficient corners
    // Compensation uses the temperature held from the previous sample
    tp = 16'sh0000;
    for (int k = 0; k < 20; k++) begin
      tmp <= (k < 2) ? 16'sh7FFF : 16'($random(seed));
      for (int i = 0; i < 3; i++) begin
        cf[i] = (k == 0) ? 10'sh200 : (k == 1) ? 10'sh0 : 10'($random(seed));
        usr[i] = (k == 0) ? 16'sh8000 : 16'($random(seed));
        raw[i] <= (k == 0) ? 16'sh7FFF : 16'($random(seed));
        i_gorb_host_model.wr(8'(8'h04 + 3 * i), {6'h00, cf[i][9:8]});
        i_gorb_host_model.wr(8'(8'h05 + 3 * i), cf[i][7:0]);
        i_gorb_host_model.wr(8'(8'h13 + 2 * i), usr[i][15:8]);
        i_gorb_host_model.wr(8'(8'h14 + 2 * i), usr[i][7:0]);
      end
      @(posedge sys_clk_in);
      sample_in <= 1'b1;
      @(posedge sys_clk_in);
      sample_in <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        e[i] = exp_rate(raw[i], usr[i], tp, cf[i]);
        rchk(8'(8'h43 + 2 * i), e[i][15:8]);
        rchk(8'(8'h44 + 2 * i), e[i][7:0]);
      end
      rchk(8'h42, tmp[7:0]);
      rchk(8'h41, tmp[15:8]);
      tp = tmp;
    end
    // Writes to read-only places
    for (int i = 0; i < 3; i++) begin
      i_gorb_host_model.wr(8'(8'h43 + 2 * i), ~e[i][15:8]);
      rchk(8'(8'h43 + 2 * i), e[i][15:8]);
    end
    i_gorb_host_model.wr(8'h75, ~ID);
    rchk(8'h75, ID);
    i_gorb_host_model.wr(8'h05, 8'h00);
    rchk(8'h05, 8'h00);
    i_gorb_host_model.wr(8'h6B, 8'h80);
    wait_load();
    rchk(8'h05, trim_in[7:0]);
    rchk(8'h13, 8'h00);
    i_gorb_host_model.wr(8'h6B, 8'h40);
    rchk(8'h6B, 8'h40);
    chk8({7'h00, sleep_out}, 8'h01);
    i_gorb_host_model.wr(8'h6C, 8'h07);
    rchk(8'h6C, 8'h07);
    chk8({5'h00, standby_out}, 8'h07);
    // Sample while asleep must leave cleared outputs alone
    tmp <= 16'h1234;
    raw[0] <= 16'sh1234;
    @(posedge sys_clk_in);
    sample_in <= 1'b1;
    @(posedge sys_clk_in);
    sample_in <= 1'b0;
    rchk(8'h43, 8'h00);
    rchk(8'h42, 8'h00);
    stop_test();
  end
endmodule // tb_gorb_register_bank
`default_nettype wire
